// ===== verilog/spicsd_pkg.sv
// What this block does
// - Master, normal speed: SCK is system clock over 4, 16, 64 or 128.
// - Master, double speed: SCK is system clock over 2, 8, 32 or 64.
// - Rate bits do nothing while the unit is a slave.
// - Fastest double-speed master SCK period is two system clocks.
// - Transfer-complete flag, status bit 7, sets when a transfer ends.
// - Interrupt requested while done flag, local enable and global enable are set.
// - Master with select pin as input: select low also sets done flag.
// - Done flag clears when the processor takes the interrupt vector.
// - Status read with done set, then data access, clears done flag.
// - Collision flag, status bit 6, sets on data write during a transfer.
// - Status read with collision set, then data access, clears both flags.
// - Writing the data register loads the shifter and starts a transfer.
// - Reading the data register returns the receive buffer.
// - Select low as input in master mode drops to slave mode.
// - Order bit set shifts LSB first, clear shifts MSB first.
// - Polarity sets SCK idle level; phase picks leading or trailing sample edge.
// - Slave select high resets the slave bit count and receive shifter and drops partial bits; the transmit shifter keeps its contents.
`default_nettype none
package spicsd_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h4c;
  localparam logic [7:0] STATUS_ADDR = 8'h4d;
  localparam logic [7:0] DATA_ADDR = 8'h4e;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_ENABLE = 6;
  localparam int CTRL_ORDER = 5;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_POLARITY = 3;
  localparam int CTRL_PHASE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;
  localparam int STAT_DONE = 7;
  localparam int STAT_COLL = 6;
  localparam int STAT_DOUBLE = 0;
  // ----------------------------------------
  // Transfer timing
  // ----------------------------------------
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam int SCK_DIV_0 = 4;
  localparam int SCK_DIV_1 = 16;
  localparam int SCK_DIV_2 = 64;
  localparam int SCK_DIV_3 = 128;
  localparam int SCK_DIV_2X_0 = 2;
  localparam int SCK_DIV_2X_1 = 8;
  localparam int SCK_DIV_2X_2 = 32;
  localparam int SCK_DIV_2X_3 = 64;

  // System clocks per SCK half period
  function automatic logic [6:0] sck_half(input logic dbl, input logic [1:0] rate);
    int div;
    div = SCK_DIV_0;
    case ({dbl, rate})
      3'b000: div = SCK_DIV_0;
      3'b001: div = SCK_DIV_1;
      3'b010: div = SCK_DIV_2;
      3'b011: div = SCK_DIV_3;
      3'b100: div = SCK_DIV_2X_0;
      3'b101: div = SCK_DIV_2X_1;
      3'b110: div = SCK_DIV_2X_2;
      default: div = SCK_DIV_2X_3;
    endcase
    return 7'(div / 2);
  endfunction : sck_half
endpackage : spicsd_pkg
`default_nettype wire

// ===== verilog/spicsd_stream_if.sv
`default_nettype none
interface spicsd_stream_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : spicsd_stream_if
`default_nettype wire

// ===== verilog/spicsd_rx_buf.sv
`default_nettype none
// Small FIFO; DEPTH must be a power of two
module spicsd_rx_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Stream
  spicsd_stream_if.store s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = s.in_valid && s.in_ready;
  assign pop = s.out_valid && s.out_ready;
  assign s.in_ready = count != (AW+1)'(DEPTH);
  assign s.out_valid = count != '0;
  assign s.out_data = mem[rd_ptr];

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= s.in_data;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : spicsd_rx_buf
`default_nettype wire

// ===== verilog/spicsd_rate_div.sv
`default_nettype none
module spicsd_rate_div (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic run_in,
  input wire logic [6:0] half_in,
  // Edge strobe
  output logic tick_out
);
  logic [6:0] cnt;
  logic wrap;

  assign wrap = cnt == half_in - 7'd1;
  assign tick_out = run_in && wrap;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else if (!run_in || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 7'd1;
    end
  end
endmodule : spicsd_rate_div
`default_nettype wire

// ===== verilog/spicsd_top.sv
`default_nettype none
module spicsd_top #(
  parameter int RX_DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Interrupt
  input wire logic global_irq_en_in,
  input wire logic irq_ack_in,
  output logic irq_out,
  // Slave select
  input wire logic ss_is_input_in,
  input wire logic ss_n_in,
  // Serial clock
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n_out,
  // Master out
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n_out,
  // Master in
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl;
  logic xfer_done;
  logic write_collision;
  logic double_rate;
  logic armed;
  logic busy;
  logic [3:0] ecnt;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic sck_q;
  logic [7:0] next_tx_sh;
  logic [7:0] next_rx_sh;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic enable;
  logic master_select;
  logic lsb_first;
  logic clock_polarity;
  logic clock_phase;
  logic is_master;
  logic is_slave;
  logic mode_fault;
  logic slave_reset;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_stat;
  logic wr_data;
  logic rd_data;
  logic data_access;
  logic refuse;
  logic start;
  logic tick;
  logic sck_edge;
  logic sample;
  logic shift_tx;
  logic last;
  logic in_bit;
  logic set_done;
  logic set_coll;
  logic clr_flags;
  logic [6:0] half;

  spicsd_stream_if #(.W(8)) rx ();

  assign enable = ctrl[spicsd_pkg::CTRL_ENABLE];
  assign master_select = ctrl[spicsd_pkg::CTRL_MASTER];
  assign lsb_first = ctrl[spicsd_pkg::CTRL_ORDER];
  assign clock_polarity = ctrl[spicsd_pkg::CTRL_POLARITY];
  assign clock_phase = ctrl[spicsd_pkg::CTRL_PHASE];
  assign is_master = enable && master_select;
  assign is_slave = enable && !master_select;
  assign mode_fault = is_master && ss_is_input_in && !ss_n_in;
  assign slave_reset = is_slave && ss_n_in;

  assign wr_ctrl = reg_wr_in && reg_addr_in == spicsd_pkg::CTRL_ADDR;
  assign wr_stat = reg_wr_in && reg_addr_in == spicsd_pkg::STATUS_ADDR;
  assign rd_stat = reg_rd_in && reg_addr_in == spicsd_pkg::STATUS_ADDR;
  assign wr_data = reg_wr_in && reg_addr_in == spicsd_pkg::DATA_ADDR;
  assign rd_data = reg_rd_in && reg_addr_in == spicsd_pkg::DATA_ADDR;
  assign data_access = wr_data || rd_data;

  // Writes are refused mid-transfer or while no room for the answer
  assign refuse = busy || !rx.in_ready;
  assign start = wr_data && enable && !refuse;

  // ----------------------------------------
  // Clock rate
  // ----------------------------------------
  // Slave never runs the divider, so the rate bits are ignored there
  assign half = spicsd_pkg::sck_half(double_rate, ctrl[1:0]);

  spicsd_rate_div u_div (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(is_master && busy),
    .half_in(half),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  assign sck_edge = is_master ? tick : (is_slave && !ss_n_in && sck_in != sck_q);
  assign sample = ecnt[0] == clock_phase;
  assign shift_tx = !sample && !(clock_phase && ecnt == 4'h0);
  assign last = sck_edge && ecnt == spicsd_pkg::LAST_EDGE;
  assign in_bit = is_master ? miso_in : mosi_in;

  always_comb begin
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    if (start) begin
      next_tx_sh = reg_wdata_in;
    end else if (sck_edge && shift_tx) begin
      next_tx_sh = lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
    end
    if (sck_edge && sample) begin
      next_rx_sh = lsb_first ? {in_bit, rx_sh[7:1]} : {rx_sh[6:0], in_bit};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      ecnt <= 4'h0;
    end else if (!enable || mode_fault || slave_reset) begin
      busy <= 1'b0;
      ecnt <= 4'h0;
    end else if (start && master_select) begin
      busy <= 1'b1;
      ecnt <= 4'h0;
    end else if (sck_edge) begin
      busy <= ecnt != spicsd_pkg::LAST_EDGE;
      ecnt <= ecnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      tx_sh <= next_tx_sh;
      rx_sh <= slave_reset ? 8'h00 : next_rx_sh;
      sck_q <= sck_in;
    end
  end

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  assign rx.in_valid = last;
  assign rx.in_data = next_rx_sh;
  assign rx.out_ready = rd_data;

  spicsd_rx_buf #(.W(8), .DEPTH(RX_DEPTH)) u_rx_buf (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .s(rx)
  );

  // ----------------------------------------
  // Registers and flags
  // ----------------------------------------
  assign set_done = last || mode_fault;
  assign set_coll = wr_data && refuse;
  assign clr_flags = armed && data_access;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= spicsd_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata_in;
      end
      if (mode_fault) begin
        ctrl[spicsd_pkg::CTRL_MASTER] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      double_rate <= 1'b0;
    end else if (wr_stat) begin
      double_rate <= reg_wdata_in[spicsd_pkg::STAT_DOUBLE];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xfer_done <= 1'b0;
      write_collision <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (set_done) begin
        xfer_done <= 1'b1;
      end else if (irq_ack_in || clr_flags) begin
        xfer_done <= 1'b0;
      end
      if (set_coll) begin
        write_collision <= 1'b1;
      end else if (clr_flags) begin
        write_collision <= 1'b0;
      end
      if (data_access) begin
        armed <= 1'b0;
      end else if (rd_stat && (xfer_done || write_collision)) begin
        armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        spicsd_pkg::CTRL_ADDR: reg_rdata_out <= ctrl;
        spicsd_pkg::STATUS_ADDR: reg_rdata_out <= {xfer_done, write_collision, 5'h00, double_rate};
        spicsd_pkg::DATA_ADDR: reg_rdata_out <= rx.out_data;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= xfer_done && ctrl[spicsd_pkg::CTRL_IRQ_EN] && global_irq_en_in;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_out <= 1'b0;
    end else if (!is_master || !busy) begin
      sck_out <= clock_polarity;
    end else if (tick) begin
      sck_out <= !sck_out;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      sck_oe_n_out <= 1'b1;
      mosi_oe_n_out <= 1'b1;
      miso_oe_n_out <= 1'b1;
    end else begin
      mosi_out <= lsb_first ? next_tx_sh[0] : next_tx_sh[7];
      miso_out <= lsb_first ? next_tx_sh[0] : next_tx_sh[7];
      sck_oe_n_out <= !(is_master && !mode_fault);
      mosi_oe_n_out <= !(is_master && !mode_fault);
      miso_oe_n_out <= !(is_slave && !ss_n_in);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [7:0] gap;
  logic [3:0] smp;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap <= 8'h01;
      smp <= 4'h0;
    end else begin
      gap <= (!(is_master && busy) || tick) ? 8'h01 : gap + 8'h01;
      if (last || (ecnt == 4'h0 && !sck_edge)) begin
        smp <= 4'h0;
      end else if (sck_edge && sample) begin
        smp <= smp + 4'h1;
      end
    end
  end

  sequence s_armed_access;
    armed && data_access && !set_done && !set_coll;
  endsequence
  sequence s_master_idle;
    (is_master && !busy && $stable(ctrl)) [*2];
  endsequence

  chk_rate_period: assert property (tick |-> gap == {1'b0, half})
    else $error("SCK half period does not match rate selection");
  chk_slave_no_div: assert property (!is_master |-> !tick)
    else $error("Divider ran in slave mode");
  chk_done_set: assert property (last |=> xfer_done)
    else $error("Done flag not set after transfer");
  chk_irq_gate: assert property (xfer_done && ctrl[7] && global_irq_en_in |=> irq_out)
    else $error("Interrupt not raised");
  chk_mode_fault: assert property (mode_fault |=> !master_select && xfer_done)
    else $error("Select low in master mode not handled");
  chk_ack_clear: assert property (irq_ack_in && !set_done |=> !xfer_done)
    else $error("Vector did not clear done flag");
  chk_flag_clear: assert property (s_armed_access |=>
      !xfer_done && !write_collision)
    else $error("Status then data access did not clear flags");
  chk_coll_set: assert property (wr_data && busy && !(sck_edge && shift_tx) |=>
      write_collision && $stable(tx_sh))
    else $error("Collision flag missing or shifter disturbed");
  chk_start_load: assert property (start && master_select && !mode_fault |=>
      busy && tx_sh == $past(reg_wdata_in))
    else $error("Data write did not start transfer");
  chk_read_buffer: assert property (rd_data |=> reg_rdata_out == $past(rx.out_data))
    else $error("Data read did not return receive buffer");
  chk_first_bit: assert property (start |=> mosi_out ==
      (lsb_first ? $past(reg_wdata_in[0]) : $past(reg_wdata_in[7])))
    else $error("First bit ignores bit order");
  chk_sck_idle: assert property (s_master_idle |-> sck_out == clock_polarity)
    else $error("SCK idle level wrong");
  chk_slave_reset: assert property (slave_reset |=> ecnt == 4'h0 && !busy)
    else $error("Slave not reset by select high");
  chk_eight_bits: assert property (last |->
      smp + {3'h0, sample} == spicsd_pkg::BITS_PER_XFER)
    else $error("Transfer did not move eight bits");
endmodule : spicsd_top
`default_nettype wire

// ===== test/spicsd_slave_model.sv
`default_nettype none
module spicsd_slave_model (
  // Clock
  input wire logic core_clk_in,
  // Serial pins
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso_out,
  // Setup from the bench: {order, polarity, phase}
  input wire logic sel_in,
  input wire logic [2:0] mode_in,
  input wire logic [7:0] tx_in,
  output logic [7:0] rx_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_sck = 1'b0;
  logic [7:0] sr = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic samp;
  logic lsb;
  // ----------------------------------------
  // Edge decode and shifting
  // ----------------------------------------
  assign lsb = mode_in[2];
  // Sample on the leading edge for phase 0, on the trailing edge for phase 1
  assign samp = (sck_in != mode_in[1]) == !mode_in[0];
  // Deselected line shows the inverse of the bit it last held
  assign miso_out = (lsb ? sr[0] : sr[7]) ^ !sel_in;
  always @(posedge core_clk_in) begin
    prev_sck <= sck_in;
    if (!sel_in) begin
      sr <= tx_in;
      cnt <= 4'h0;
    end else if (sck_in != prev_sck) begin
      if (samp) begin
        rx_out <= lsb ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
        cnt <= cnt + 4'h1;
      end else if (!(mode_in[0] && cnt == 4'h0)) begin
        // First leading edge of phase 1 only presents the first bit
        sr <= lsb ? sr >> 1 : sr << 1;
      end
    end
  end
endmodule : spicsd_slave_model
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [7:0] CT = spicsd_pkg::CTRL_ADDR;
  localparam logic [7:0] ST = spicsd_pkg::STATUS_ADDR;
  localparam logic [7:0] DT = spicsd_pkg::DATA_ADDR;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic global_irq_en_in = 1'b0;
  logic irq_ack_in = 1'b0;
  logic ss_is_input_in = 1'b0;
  logic ss_n_in = 1'b1;
  logic [7:0] reg_rdata_out;
  logic irq_out, sck_out, mosi_out, miso_in, sck_oe_n, mosi_oe_n, miso_oe_n, miso_pin;
  logic ext_sck = 1'b0;
  logic ext_mosi = 1'b0;
  logic sel = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] slv_tx = 8'h00;
  logic [7:0] slv_rx, v, m, t;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int divs [8] = '{spicsd_pkg::SCK_DIV_0, spicsd_pkg::SCK_DIV_1, spicsd_pkg::SCK_DIV_2,
    spicsd_pkg::SCK_DIV_3, spicsd_pkg::SCK_DIV_2X_0, spicsd_pkg::SCK_DIV_2X_1,
    spicsd_pkg::SCK_DIV_2X_2, spicsd_pkg::SCK_DIV_2X_3};
  spicsd_top u_spicsd_top (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .global_irq_en_in(global_irq_en_in), .irq_ack_in(irq_ack_in), .irq_out(irq_out),
    .ss_is_input_in(ss_is_input_in), .ss_n_in(ss_n_in), .sck_in(ext_sck), .sck_out(sck_out),
    .sck_oe_n_out(sck_oe_n), .mosi_in(ext_mosi), .mosi_out(mosi_out),
    .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_in), .miso_out(miso_pin),
    .miso_oe_n_out(miso_oe_n));
  spicsd_slave_model u_spicsd_slave_model (.core_clk_in(core_clk_in), .sck_in(sck_out),
    .mosi_in(mosi_out), .miso_out(miso_in), .sel_in(sel), .mode_in(mode), .tx_in(slv_tx),
    .rx_out(slv_rx));
  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    idle(1);
    reg_wr_in = 1'b0;
    idle(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    idle(1);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
    idle(1);
  endtask : rd
  task automatic wait_done(output logic [7:0] s);
    for (int i = 0; i < 600; i++) begin
      rd(ST, s);
      if (s[7] === 1'b1) break;
    end
  endtask : wait_done
  task automatic start(input logic [7:0] mb, input logic [7:0] sb);
    sel = 1'b0;
    slv_tx = sb;
    idle(1);
    sel = 1'b1;
    wr(DT, mb);
  endtask : start
  // External master at a quarter of the core clock, mode 0, MSB first
  task automatic ext_xfer(input logic [7:0] sx, input int nb, output logic [7:0] got);
    got = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      ext_mosi = sx[i];
      idle(2);
      got[i] = miso_pin;
      ext_sck = 1'b1;
      idle(2);
      ext_sck = 1'b0;
    end
    idle(2);
  endtask : ext_xfer
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    rd(CT, v);
    chk(v, spicsd_pkg::CTRL_RESET);
    rd(ST, v);
    chk(v, 8'h00);
    wr(ST, 8'hff);
    rd(ST, v);
    chk(v, 8'h01);
    rd(8'h4f, v);
    chk(v, 8'h00);
    wr(ST, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      mode = {i[1] ^ i[0], i[1], i[0]};
      wr(CT, {2'b01, mode[2], 1'b1, mode[1], mode[0], 2'b00});
      idle(2);
      chk({7'h00, sck_out}, {7'h00, mode[1]});
      m = 8'h96 ^ 8'(i * 37);
      t = 8'h3c ^ 8'(i * 19);
      start(m, t);
      wait_done(v);
      chk(v, 8'h80);
      chk(slv_rx, m);
      rd(DT, v);
      chk(v, t);
      rd(ST, v);
      chk(v, 8'h00);
    end
    $display("test modes done");
    mode = 3'h0;
    for (int r = 0; r < 8; r++) begin
      wr(ST, {7'h00, r[2]});
      wr(CT, {6'h14, r[1:0]});
      start(8'h5a, 8'h00);
      n = 0;
      while (sck_out === 1'b0 && n < 300) begin
        idle(1);
        n++;
      end
      n = 0;
      while (sck_out === 1'b1 && n < 300) begin
        idle(1);
        n++;
      end
      chk(8'(n), 8'(divs[r] / 2));
      wait_done(v);
      rd(DT, v);
      chk(v, 8'h00);
    end
    wr(ST, 8'h00);
    $display("test rates done");
    wr(CT, 8'h50);
    start(8'hc3, 8'h11);
    wr(DT, 8'hff);
    wait_done(v);
    chk(v, 8'hc0);
    chk(slv_rx, 8'hc3);
    start(8'h24, 8'h22);
    wait_done(v);
    chk(v, 8'h80);
    wr(DT, 8'h77);
    idle(40);
    rd(ST, v);
    chk(v, 8'h40);
    rd(DT, v);
    chk(v, 8'h11);
    rd(DT, v);
    chk(v, 8'h22);
    rd(ST, v);
    chk(v, 8'h00);
    $display("test collision and buffer done");
    wr(CT, 8'hd0);
    start(8'h0f, 8'hf0);
    idle(40);
    chk({7'h00, irq_out}, 8'h00);
    global_irq_en_in = 1'b1;
    idle(2);
    chk({7'h00, irq_out}, 8'h01);
    irq_ack_in = 1'b1;
    idle(1);
    irq_ack_in = 1'b0;
    idle(2);
    chk({7'h00, irq_out}, 8'h00);
    rd(ST, v);
    chk(v, 8'h00);
    rd(DT, v);
    chk(v, 8'hf0);
    global_irq_en_in = 1'b0;
    $display("test interrupt done");
    wr(CT, 8'h50);
    sel = 1'b0;
    ss_is_input_in = 1'b1;
    idle(2);
    ss_n_in = 1'b0;
    idle(4);
    rd(CT, v);
    chk(v, 8'h40);
    chk({6'h00, sck_oe_n, mosi_oe_n}, 8'h03);
    rd(ST, v);
    chk(v, 8'h80);
    ss_n_in = 1'b1;
    ss_is_input_in = 1'b0;
    $display("test select fault done");
    wr(CT, 8'h43);
    wr(DT, 8'ha5);
    ss_n_in = 1'b0;
    ext_xfer(8'h3c, 3, v);
    ss_n_in = 1'b1;
    rd(ST, v);
    chk(v, 8'h00);
    wr(DT, 8'ha5);
    ss_n_in = 1'b0;
    ext_xfer(8'h3c, 8, t);
    chk(t, 8'ha5);
    chk({5'h00, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h06);
    rd(ST, v);
    chk(v, 8'h80);
    rd(DT, v);
    chk(v, 8'h3c);
    ss_n_in = 1'b1;
    $display("test slave done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
